// ### core/car_regs.sv
// Purpose: Architectural registers of an 8-bit core with stack engine
// Assumes: Instruction decode drives op/op_valid; ops taken when not busy
// Notes:   Multi-byte stack sequences move one byte per cycle
// Behaviour
// RL1 - Registers reached by operations, never by addresses
// RL2 - Accumulator is 8 bits, holds results
// RL3 - Two 8-bit index registers
// RL4 - Second index untouched by interrupt entry/exit
// RL5 - 16-bit program counter from two bytes
// RL6 - Flags reset 111x1xxx
// RL7 - Flags pushed and popped by instructions
// RL8 - Half carry from bit 3 on add
// RL9 - Sign flag copies result bit 7
// RL10 - Zero flag set on zero result
// RL11 - Carry set on overflow or borrow
// RL12 - Set and clear carry operations
// RL13 - Priority encoding in bits 5 and 3
// RL14 - Interrupt entry loads priority bits
// RL15 - Mask, unmask, return, halt, wait change priority
// RL16 - 16-bit stack pointer, upper byte fixed
// RL17 - Post-decrement push, pre-increment pop
// RL18 - Stack pointer reset to 01FF
// RL19 - Stack pointer wraps silently
// RL20 - Stack low byte directly loadable
// RL21 - Interrupt pushes low PC byte first
// RL22 - Call uses two bytes, interrupt five
// RL23 - Entry order PROG_COUNTER_LOW, PROG_COUNTER_HIGH, X, A, flags
`timescale 1ns/1ps
`include "car_params.svh"
module car_regs
  import car_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Operation request
  input  wire car_op_e     op,
  input  wire logic        op_valid,
  input  wire logic [7:0]  operand,
  input  wire logic        carry_in,
  input  wire logic        carry_valid,
  input  wire logic [15:0] target,
  input  wire logic [1:0]  irq_prio,
  output logic             busy,
  // Register state
  output logic [7:0]       work_accumulator,
  output logic [7:0]       first_index_reg,
  output logic [7:0]       second_index_reg,
  output logic [15:0]      prog_counter,
  output logic [7:0]       flags_reg,
  output logic [15:0]      stack_ptr
);

  car_sp_if sp_io ();

  car_stack_unit u_stack (
    .mclk  (mclk),
    .rst   (rst),
    .sp_io (sp_io)
  );

  // Stack RAM kept local: core registers have no memory address
  car_byte_t   stk_mem [0:`CAR_STACK_DEPTH-1]; // see RL1

  car_seq_e    seq_q, seq_d;
  logic [2:0]  cnt_q, cnt_d;
  logic [7:0]  acc_q, acc_d;
  logic [7:0]  ix_q, ix_d;
  logic [7:0]  iy_q, iy_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0]  cc_q, cc_d;
  logic [15:0] tgt_q, tgt_d;
  logic [1:0]  prio_q, prio_d;
  logic        mem_we;
  car_byte_t   mem_wdata;
  car_byte_t   pop_byte;
  logic        take;
  logic [8:0]  sum9;
  logic [4:0]  half5;
  logic        cin;
  logic [7:0]  res;

  assign busy     = (seq_q != SEQ_IDLE);
  assign take     = op_valid && !busy;
  assign pop_byte = stk_mem[sp_io.sp_pop[7:0]];

  // Set flags from a result: sign and zero always
  function automatic logic [7:0] nz_flags(input logic [7:0] cc,
                                          input logic [7:0] r);
    logic [7:0] f;
    f = cc;
    f[`CAR_BIT_SIGN] = r[7]; // see RL9
    f[`CAR_BIT_ZERO] = (r == 8'h00); // see RL10
    return f;
  endfunction

  // ALU datapath for add, add with carry and subtract
  always_comb begin
    cin   = (op == OP_ADD_CARRY) ? cc_q[`CAR_BIT_CARRY] : 1'b0;
    sum9  = 9'h000;
    half5 = 5'h00;
    res   = operand;
    if (op == OP_SUB) begin
      sum9 = {1'b0, acc_q} - {1'b0, operand};
      res  = sum9[7:0];
    end else if (op == OP_ADD || op == OP_ADD_CARRY) begin
      sum9  = {1'b0, acc_q} + {1'b0, operand} + {8'h00, cin};
      half5 = {1'b0, acc_q[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
      res   = sum9[7:0];
    end
  end

  always_comb begin
    seq_d     = seq_q;
    cnt_d     = cnt_q;
    acc_d     = acc_q;
    ix_d      = ix_q;
    iy_d      = iy_q;
    pc_d      = pc_q;
    cc_d      = cc_q;
    tgt_d     = tgt_q;
    prio_d    = prio_q;
    mem_we    = 1'b0;
    mem_wdata = 8'h00;
    sp_io.push      = 1'b0;
    sp_io.pop       = 1'b0;
    sp_io.reset_sp  = 1'b0;
    sp_io.load      = 1'b0;
    sp_io.load_data = operand;
    case (seq_q)
      SEQ_IDLE: begin
        if (take) begin
          case (op)
            OP_LOAD_A: begin
              acc_d = operand; // see RL2
              cc_d  = nz_flags(cc_q, operand);
            end
            OP_LOAD_X: begin
              ix_d = operand; // see RL3
              cc_d = nz_flags(cc_q, operand);
            end
            OP_LOAD_Y: begin
              iy_d = operand; // see RL3
              cc_d = nz_flags(cc_q, operand);
            end
            OP_ADD, OP_ADD_CARRY, OP_SUB, OP_RESULT: begin
              acc_d = res; // see RL2
              cc_d  = nz_flags(cc_q, res);
              if (op != OP_RESULT) begin
                cc_d[`CAR_BIT_CARRY] = sum9[8]; // see RL11
              end else if (carry_valid) begin
                cc_d[`CAR_BIT_CARRY] = carry_in; // see RL11
              end
              if (op != OP_SUB && op != OP_RESULT) begin
                cc_d[`CAR_BIT_HALF] = half5[4]; // see RL8
              end
            end
            OP_SET_CARRY: cc_d[`CAR_BIT_CARRY] = 1'b1; // see RL12
            OP_CLEAR_CARRY: cc_d[`CAR_BIT_CARRY] = 1'b0; // see RL12
            OP_IRQ_UNMASK, OP_HALT, OP_WAIT_IRQ: begin
              // Level 0: hi set, lo clear
              cc_d[`CAR_BIT_PRIO_HI] = 1'b1; // see RL13 see RL15
              cc_d[`CAR_BIT_PRIO_LO] = 1'b0; // see RL15
            end
            OP_IRQ_MASK: begin
              cc_d[`CAR_BIT_PRIO_HI] = 1'b1; // see RL13 see RL15
              cc_d[`CAR_BIT_PRIO_LO] = 1'b1; // see RL15
            end
            OP_PUSH_FLAGS: begin
              mem_we     = 1'b1; // see RL7
              mem_wdata  = cc_q;
              sp_io.push = 1'b1;
            end
            OP_POP_FLAGS: begin
              cc_d      = pop_byte; // see RL7 see RL15
              sp_io.pop = 1'b1;
            end
            OP_JUMP: pc_d = target; // see RL5
            OP_CALL: begin
              tgt_d = target;
              cnt_d = 3'h0;
              seq_d = SEQ_CALL;
            end
            OP_RETURN: begin
              cnt_d = 3'h0;
              seq_d = SEQ_RET;
            end
            OP_IRQ_ENTRY: begin
              tgt_d  = target;
              prio_d = irq_prio;
              cnt_d  = 3'h0;
              seq_d  = SEQ_IRQ_IN;
            end
            OP_IRQ_RETURN: begin
              cnt_d = 3'h0;
              seq_d = SEQ_IRQ_OUT;
            end
            OP_STACK_RESET: sp_io.reset_sp = 1'b1; // see RL18
            OP_LOAD_STACK_LOW: sp_io.load = 1'b1; // see RL20
            default: begin
            end
          endcase
        end
      end
      SEQ_IRQ_IN: begin
        // Second index is never part of the saved context
        mem_we     = 1'b1; // see RL4
        sp_io.push = 1'b1; // see RL21
        case (cnt_q)
          3'h0:    mem_wdata = pc_q[7:0]; // see RL21 see RL23
          3'h1:    mem_wdata = pc_q[15:8]; // see RL23
          3'h2:    mem_wdata = ix_q; // see RL23
          3'h3:    mem_wdata = acc_q; // see RL23
          default: mem_wdata = cc_q; // see RL23
        endcase
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == `CAR_IRQ_BYTES - 3'h1) begin // see RL22
          pc_d = tgt_q;
          cc_d[`CAR_BIT_PRIO_HI] = prio_q[1]; // see RL14
          cc_d[`CAR_BIT_PRIO_LO] = prio_q[0]; // see RL14
          seq_d = SEQ_IDLE;
        end
      end
      SEQ_IRQ_OUT: begin
        sp_io.pop = 1'b1;
        case (cnt_q)
          3'h0:    cc_d = pop_byte; // see RL15 see RL23
          3'h1:    acc_d = pop_byte; // see RL23
          3'h2:    ix_d = pop_byte; // see RL23
          3'h3:    pc_d[15:8] = pop_byte; // see RL23
          default: pc_d[7:0] = pop_byte; // see RL23
        endcase
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == `CAR_IRQ_BYTES - 3'h1) begin // see RL22
          seq_d = SEQ_IDLE;
        end
      end
      SEQ_CALL: begin
        mem_we     = 1'b1;
        sp_io.push = 1'b1;
        mem_wdata  = (cnt_q == 3'h0) ? pc_q[7:0] : pc_q[15:8];
        cnt_d      = cnt_q + 3'h1;
        if (cnt_q == `CAR_CALL_BYTES - 3'h1) begin // see RL22
          pc_d  = tgt_q;
          seq_d = SEQ_IDLE;
        end
      end
      SEQ_RET: begin
        sp_io.pop = 1'b1;
        pc_d = (cnt_q == 3'h0) ? {pop_byte, pc_q[7:0]}
                               : {pc_q[15:8], pop_byte};
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == `CAR_CALL_BYTES - 3'h1) begin // see RL22
          seq_d = SEQ_IDLE;
        end
      end
      default: seq_d = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seq_q  <= SEQ_IDLE;
      cnt_q  <= 3'h0;
      acc_q  <= `CAR_DATA_RESET;
      ix_q   <= `CAR_DATA_RESET;
      iy_q   <= `CAR_DATA_RESET;
      pc_q   <= `CAR_PC_RESET;
      cc_q   <= `CAR_FLAGS_RESET; // see RL6
      tgt_q  <= `CAR_PC_RESET;
      prio_q <= 2'h0;
    end else begin
      seq_q  <= seq_d;
      cnt_q  <= cnt_d;
      acc_q  <= acc_d;
      ix_q   <= ix_d;
      iy_q   <= iy_d;
      pc_q   <= pc_d;
      cc_q   <= cc_d;
      tgt_q  <= tgt_d;
      prio_q <= prio_d;
    end
  end

  // Write at the current pointer, before it moves down
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      stk_mem[sp_io.sp[7:0]] <= mem_wdata; // see RL17
    end
  end

  assign work_accumulator = acc_q;
  assign first_index_reg  = ix_q;
  assign second_index_reg = iy_q;
  assign prog_counter     = pc_q;
  assign flags_reg        = cc_q;
  assign stack_ptr        = sp_io.sp;

  a_half_carry_add: assert property (@(posedge mclk) disable iff (rst) // see RL8
    (take && op == OP_ADD) |=> flags_reg[4] ==
      ((5'({1'b0, $past(acc_q[3:0])}) + 5'({1'b0, $past(operand[3:0])}))
        > 5'h0F))
    else $error("half carry wrong after add");
  a_sign_zero: assert property (@(posedge mclk) disable iff (rst) // see RL9
    (take && (op == OP_ADD || op == OP_SUB || op == OP_RESULT)) |=>
      flags_reg[2] == work_accumulator[7] &&
      flags_reg[1] == (work_accumulator == 8'h00))
    else $error("sign or zero flag disagrees with result");
  a_carry_force: assert property (@(posedge mclk) disable iff (rst) // see RL12
    (take && op == OP_SET_CARRY) |=> flags_reg[0] ##1
      (!$past(take) || $past(op) != OP_CLEAR_CARRY || !flags_reg[0]))
    else $error("carry force failed");
  a_sub_borrow: assert property (@(posedge mclk) disable iff (rst) // see RL11
    (take && op == OP_SUB && operand > acc_q) |=> flags_reg[0])
    else $error("borrow not flagged");
  a_irq_five_bytes: assert property (@(posedge mclk) disable iff (rst) // see RL22
    (take && op == OP_IRQ_ENTRY) |=> busy[*5] ##1
      (!busy && stack_ptr[7:0] == $past(stack_ptr[7:0], 6) - 8'h05))
    else $error("interrupt entry did not use five stack bytes");
  a_call_two_bytes: assert property (@(posedge mclk) disable iff (rst) // see RL22
    (take && op == OP_CALL) |=> busy[*2] ##1
      (!busy && stack_ptr[7:0] == $past(stack_ptr[7:0], 3) - 8'h02))
    else $error("call did not use two stack bytes");
  a_irq_prio_load: assert property (@(posedge mclk) disable iff (rst) // see RL14
    (take && op == OP_IRQ_ENTRY) ##5 1'b1 |=>
      {flags_reg[5], flags_reg[3]} == $past(irq_prio, 6))
    else $error("priority bits not loaded on entry");
  a_y_untouched: assert property (@(posedge mclk) disable iff (rst) // see RL4
    busy |=> $stable(second_index_reg))
    else $error("second index changed during stack sequence");
  a_sp_reset_op: assert property (@(posedge mclk) disable iff (rst) // see RL18
    (take && op == OP_STACK_RESET) |=> stack_ptr == 16'h01FF)
    else $error("stack reset did not restore pointer");
  a_unmask_level: assert property (@(posedge mclk) disable iff (rst) // see RL15
    (take && op == OP_IRQ_UNMASK) |=> flags_reg[5] && !flags_reg[3])
    else $error("unmask did not select level 0");

endmodule

// ### inc/car_params.svh
// Purpose: Constants for the CPU architectural register block
// Assumes: Included by design files by bare name
// Notes:   Undefined reset bits of the flags register are taken as zero
`ifndef CAR_PARAMS_SVH
`define CAR_PARAMS_SVH

// Stack pointer layout and reset
`define CAR_SP_HIGH       8'h01
`define CAR_SP_LOW_RESET  8'hFF
`define CAR_SP_RESET      16'h01FF
`define CAR_STACK_DEPTH   256

// Flags register reset pattern and bit positions
`define CAR_FLAGS_RESET   8'hE8
`define CAR_BIT_PRIO_HI   5
`define CAR_BIT_HALF      4
`define CAR_BIT_PRIO_LO   3
`define CAR_BIT_SIGN      2
`define CAR_BIT_ZERO      1
`define CAR_BIT_CARRY     0

// Stack bytes used by calls and interrupts
`define CAR_CALL_BYTES    3'h2
`define CAR_IRQ_BYTES     3'h5

// Accumulator, index and program counter reset values
`define CAR_DATA_RESET    8'h00
`define CAR_PC_RESET      16'h0000

`endif

// ### inc/car_pkg.sv
// Purpose: Types for the CPU architectural register block
// Assumes: Constants live in car_params.svh
// Notes:   Operation codes are the instruction effects this block sees
package car_pkg;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_LOAD_A,
    OP_LOAD_X,
    OP_LOAD_Y,
    OP_ADD,
    OP_ADD_CARRY,
    OP_SUB,
    OP_RESULT,
    OP_SET_CARRY,
    OP_CLEAR_CARRY,
    OP_IRQ_UNMASK,
    OP_IRQ_MASK,
    OP_HALT,
    OP_WAIT_IRQ,
    OP_PUSH_FLAGS,
    OP_POP_FLAGS,
    OP_CALL,
    OP_RETURN,
    OP_JUMP,
    OP_IRQ_ENTRY,
    OP_IRQ_RETURN,
    OP_STACK_RESET,
    OP_LOAD_STACK_LOW
  } car_op_e;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_IRQ_IN,
    SEQ_IRQ_OUT,
    SEQ_CALL,
    SEQ_RET
  } car_seq_e;

  typedef logic [7:0] car_byte_t;

endpackage

// ### inc/car_sp_if.sv
// Purpose: Carrier between register core and stack pointer unit
// Assumes: One request at most per cycle
// Notes:   sp_pop is the pre-incremented address used for pops
`timescale 1ns/1ps
interface car_sp_if;
  logic        push;
  logic        pop;
  logic        reset_sp;
  logic        load;
  logic [7:0]  load_data;
  logic [15:0] sp;
  logic [15:0] sp_pop;

  modport core (output push, pop, reset_sp, load, load_data,
                input  sp, sp_pop);
  modport unit (input  push, pop, reset_sp, load, load_data,
                output sp, sp_pop);
endinterface

// ### core/car_stack_unit.sv
// Purpose: Stack pointer with fixed upper byte
// Assumes: Requests are mutually exclusive, reset_sp wins if not
// Notes:   Low byte wraps silently in both directions
`timescale 1ns/1ps
`include "car_params.svh"
module car_stack_unit
  import car_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Requests from the core
  car_sp_if.unit   sp_io
);

  logic [7:0] low_q;
  logic [7:0] low_d;

  always_comb begin
    low_d = low_q;
    if (sp_io.reset_sp) begin
      low_d = `CAR_SP_LOW_RESET; // see RL18
    end else if (sp_io.load) begin
      low_d = sp_io.load_data; // see RL20
    end else if (sp_io.push) begin
      low_d = low_q - 8'h01; // see RL17 see RL19
    end else if (sp_io.pop) begin
      low_d = low_q + 8'h01; // see RL17 see RL19
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_q <= `CAR_SP_LOW_RESET; // see RL18
    end else begin
      low_q <= low_d;
    end
  end

  // Upper byte is wired, never stored
  assign sp_io.sp     = {`CAR_SP_HIGH, low_q}; // see RL16
  assign sp_io.sp_pop = {`CAR_SP_HIGH, low_q + 8'h01};

  a_sp_push_wrap: assert property (@(posedge mclk) disable iff (rst) // see RL19
    (sp_io.push && !sp_io.reset_sp && !sp_io.load && low_q == 8'h00)
      |=> low_q == 8'hFF)
    else $error("stack pointer did not wrap on push");

  a_sp_pop_wrap: assert property (@(posedge mclk) disable iff (rst) // see RL19
    (sp_io.pop && !sp_io.push && !sp_io.reset_sp && !sp_io.load
      && low_q == 8'hFF) |=> low_q == 8'h00)
    else $error("stack pointer did not wrap on pop");

  a_sp_upper_fixed: assert property (@(posedge mclk) disable iff (rst) // see RL16
    sp_io.sp[15:8] == 8'h01)
    else $error("stack pointer upper byte moved");

endmodule

// ### testbench/tb.sv
// Purpose: Self-checking bench for the CPU architectural register block
// Assumes: Ops are driven 1 ns after the rising edge, one at a time
// Notes:   Stack contents are read back by moving the pointer and popping
`timescale 1ns/1ps
`include "car_params.svh"

`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end

module tb
  import car_pkg::*;
;
  logic        mclk;
  logic        rst;
  car_op_e     op;
  logic        op_valid;
  logic [7:0]  operand;
  logic        carry_in;
  logic        carry_valid;
  logic [15:0] target;
  logic [1:0]  irq_prio;
  logic        busy;
  logic [7:0]  work_accumulator;
  logic [7:0]  first_index_reg;
  logic [7:0]  second_index_reg;
  logic [15:0] prog_counter;
  logic [7:0]  flags_reg;
  logic [15:0] stack_ptr;
  int          n_errors;
  int          n_tests;
  // Priority ops and the {bit5,bit3} they leave behind
  car_op_e     prio_ops [6];
  logic [1:0]  prio_exp [6];
  // Saved context expected at FB..FF after interrupt entry
  logic [7:0]  ctx_exp  [5];

  car_regs uut (
    .mclk             (mclk),
    .rst              (rst),
    .op               (op),
    .op_valid         (op_valid),
    .operand          (operand),
    .carry_in         (carry_in),
    .carry_valid      (carry_valid),
    .target           (target),
    .irq_prio         (irq_prio),
    .busy             (busy),
    .work_accumulator (work_accumulator),
    .first_index_reg  (first_index_reg),
    .second_index_reg (second_index_reg),
    .prog_counter     (prog_counter),
    .flags_reg        (flags_reg),
    .stack_ptr        (stack_ptr)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic end_sim;
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic do_reset;
    rst = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    rst = 1'b0;
  endtask

  // One operation; nb is the number of busy cycles it must take
  task automatic run(input car_op_e o, input logic [7:0] d,
                     input logic [15:0] t, input int nb);
    int n;
    op       = o;
    operand  = d;
    target   = t;
    op_valid = 1'b1;
    @(posedge mclk);
    #1;
    op_valid = 1'b0;
    n = 0;
    while (busy === 1'b1 && n < 10) begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK(n, nb)
    // Idle edge so the next call never re-raises op_valid at once
    @(posedge mclk);
    #1;
  endtask

  // Long enough for a few hundred ops; a hang counts as a failure
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end

  initial begin
    n_errors    = 0;
    n_tests     = 0;
    op          = OP_NOP;
    op_valid    = 1'b0;
    operand     = 8'h00;
    carry_in    = 1'b0;
    carry_valid = 1'b0;
    target      = 16'h0000;
    irq_prio    = 2'h0;
    prio_ops = '{OP_IRQ_MASK, OP_IRQ_UNMASK, OP_IRQ_MASK, OP_HALT,
                 OP_IRQ_MASK, OP_WAIT_IRQ};
    prio_exp = '{2'h3, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2};
    ctx_exp  = '{8'hEC, 8'hC5, 8'hD3, 8'hE1, 8'hF7};
    do_reset();
    `CHK(flags_reg, `CAR_FLAGS_RESET)
    `CHK(stack_ptr, `CAR_SP_RESET)
    `CHK(busy, 1'b0)

    // Arithmetic flags, with full flag byte tracked by hand
    run(OP_LOAD_A, 8'h0F, 16'h0000, 0);
    `CHK(flags_reg, 8'hE8)
    run(OP_ADD, 8'h01, 16'h0000, 0);
    `CHK(work_accumulator, 8'h10)
    `CHK(flags_reg, 8'hF8)
    run(OP_ADD, 8'hF0, 16'h0000, 0);
    `CHK(work_accumulator, 8'h00)
    `CHK(flags_reg, 8'hEB)
    run(OP_ADD_CARRY, 8'h0F, 16'h0000, 0);
    `CHK(work_accumulator, 8'h10)
    `CHK(flags_reg, 8'hF8)
    run(OP_SUB, 8'h11, 16'h0000, 0);
    `CHK(work_accumulator, 8'hFF)
    `CHK(flags_reg, 8'hFD)
    run(OP_CLEAR_CARRY, 8'h00, 16'h0000, 0);
    `CHK(flags_reg, 8'hFC)
    run(OP_SET_CARRY, 8'h00, 16'h0000, 0);
    `CHK(flags_reg, 8'hFD)
    run(OP_RESULT, 8'h00, 16'h0000, 0);
    `CHK(flags_reg, 8'hFB)
    carry_valid = 1'b1;
    run(OP_RESULT, 8'h80, 16'h0000, 0);
    `CHK(flags_reg, 8'hFC)
    carry_valid = 1'b0;
    run(OP_LOAD_X, 8'h00, 16'h0000, 0);
    `CHK(first_index_reg, 8'h00)
    `CHK(flags_reg, 8'hFA)
    run(OP_LOAD_Y, 8'h80, 16'h0000, 0);
    `CHK(second_index_reg, 8'h80)
    `CHK(flags_reg, 8'hFC)

    // Mask, unmask, halt and wait priority ops
    for (int i = 0; i < 6; i++) begin
      run(prio_ops[i], 8'h00, 16'h0000, 0);
      `CHK({flags_reg[5], flags_reg[3]}, prio_exp[i])
    end

    // Wrap both ways through the low byte, flags survive the round trip
    run(OP_LOAD_STACK_LOW, 8'h00, 16'h0000, 0);
    `CHK(stack_ptr, 16'h0100)
    run(OP_PUSH_FLAGS, 8'h00, 16'h0000, 0);
    `CHK(stack_ptr, 16'h01FF)
    run(OP_IRQ_MASK, 8'h00, 16'h0000, 0);
    `CHK(flags_reg, 8'hFC)
    run(OP_POP_FLAGS, 8'h00, 16'h0000, 0);
    `CHK(flags_reg, 8'hF4)
    `CHK(stack_ptr, 16'h0100)
    run(OP_STACK_RESET, 8'h00, 16'h0000, 0);
    `CHK(stack_ptr, `CAR_SP_RESET)

    // Mid-run reset, then interrupt entry and return
    do_reset();
    `CHK(work_accumulator, `CAR_DATA_RESET)
    `CHK(prog_counter, `CAR_PC_RESET)
    run(OP_LOAD_Y, 8'h5A, 16'h0000, 0);
    run(OP_LOAD_X, 8'hD3, 16'h0000, 0);
    run(OP_LOAD_A, 8'hC5, 16'h0000, 0);
    run(OP_JUMP, 8'h00, 16'hE1F7, 0);
    `CHK(prog_counter, 16'hE1F7)
    irq_prio = 2'h1;
    run(OP_IRQ_ENTRY, 8'h00, 16'h8040, 5);
    `CHK(prog_counter, 16'h8040)
    `CHK(stack_ptr, 16'h01FA)
    `CHK(flags_reg, 8'hCC)
    `CHK(second_index_reg, 8'h5A)
    // Popped bytes carry bits 7 and 6 set, so each reads back whole
    for (int i = 0; i < 5; i++) begin
      run(OP_LOAD_STACK_LOW, 8'hFA + 8'(i), 16'h0000, 0);
      run(OP_POP_FLAGS, 8'h00, 16'h0000, 0);
      `CHK(flags_reg, ctx_exp[i])
      `CHK(stack_ptr, {8'h01, 8'hFB + 8'(i)})
    end
    run(OP_LOAD_STACK_LOW, 8'hFA, 16'h0000, 0);
    run(OP_LOAD_A, 8'h00, 16'h0000, 0);
    run(OP_LOAD_X, 8'h00, 16'h0000, 0);
    run(OP_IRQ_RETURN, 8'h00, 16'h0000, 5);
    `CHK(work_accumulator, 8'hC5)
    `CHK(first_index_reg, 8'hD3)
    `CHK(second_index_reg, 8'h5A)
    `CHK(flags_reg, 8'hEC)
    `CHK(prog_counter, 16'hE1F7)
    `CHK(stack_ptr, 16'h01FF)

    // Subroutine call and return use two bytes
    run(OP_CALL, 8'h00, 16'h1234, 2);
    `CHK(prog_counter, 16'h1234)
    `CHK(stack_ptr, 16'h01FD)
    run(OP_RETURN, 8'h00, 16'h0000, 2);
    `CHK(prog_counter, 16'hE1F7)
    `CHK(stack_ptr, 16'h01FF)
    end_sim();
  end
endmodule
